/* File: inc/ata_cmd_defines.svh */
// named opcodes, codes, bit positions, reset values and identification words
`ifndef ATA_CMD_DEFINES_SVH
`define ATA_CMD_DEFINES_SVH

// ------------------------------------------------------------
// opcodes
// ------------------------------------------------------------
`define OP_DIAG 8'h90
`define OP_IDLE_IMM 8'hE1
`define OP_STBY_IMM 8'hE0
`define OP_CHK_PWR 8'hE5
`define OP_SLEEP 8'hE6
`define OP_SET_FEAT 8'hEF
`define OP_ATAPI_IDENT 8'hA1
`define OP_ATA_IDENT 8'hEC
`define OP_PACKET 8'hA0
`define OP_SOFT_RST 8'h08

// ------------------------------------------------------------
// features and transfer mode codes
// ------------------------------------------------------------
`define FEAT_XFER 8'h03
`define FEAT_NOREVERT 8'h66
`define FEAT_REVERT 8'hCC
`define FEAT_DMA_BIT 0
`define MODE_PIO_DEF 8'h00
`define MODE_PIO2_NORDY 8'h01
`define MODE_PIO_BASE 8'h08
`define MODE_PIO_LAST 8'h0C
`define MODE_SW_BASE 8'h10
`define MODE_SW_LAST 8'h12
`define MODE_MW_BASE 8'h20
`define MODE_MW_LAST 8'h22
`define PIO_NUM_DEF 3'h4
`define PIO_NUM_NORDY 3'h2
`define DMA_NUM_DEF 3'h2

// ------------------------------------------------------------
// status, error and reason values
// ------------------------------------------------------------
`define ST_BSY 7
`define ST_DRDY 6
`define ST_DSC 4
`define ST_DRQ 3
`define ST_CHK 0
`define ERR_ABRT_BIT 2
`define ERR_ABORT 8'h04
`define ERR_CLEAR 8'h00
`define ERR_RESET 8'h01
`define IRSN_RESET 8'h01
`define PWR_STANDBY 8'h00
`define PWR_IDLE 8'hFF
`define MIN_RW_BYTES 16'h0200
`define IDENT_LAST 8'hFF

// ------------------------------------------------------------
// identification block
// ------------------------------------------------------------
`define IDW_CONFIG 8'h00
`define IDV_CONFIG 16'h81C0
`define IDW_BUF_TYPE 8'h14
`define IDV_BUF_TYPE 16'h4002
`define IDW_BUF_SIZE 8'h15
`define IDV_BUF_SIZE 16'h02D8
`define IDW_CAPS 8'h31
`define IDV_CAPS 16'h0F00
`define IDW_PIO_TIM 8'h33
`define IDW_DMA_TIM 8'h34
`define IDV_TIM 16'h0200
`define IDW_VALID 8'h35
`define IDV_VALID 16'h0002
`define IDW_SW_DMA 8'h3E
`define IDW_MW_DMA 8'h3F
`define IDV_DMA_MODES 16'h0407
`define IDW_PIO_ADV 8'h40
`define IDV_PIO_ADV 16'h0003
`define IDW_CYC_FIRST 8'h41
`define IDW_CYC_LAST 8'h44
`define IDV_CYC 16'h0078
`define IDV_ZERO 16'h0000

`endif

/* File: inc/ata_cmd_pkg.sv */
// types shared by the command decoder files
package ata_cmd_pkg;
  typedef enum logic [5:0] {
    S_IDLE = 6'h01,
    S_DIAG = 6'h02,
    S_IDENT = 6'h04,
    S_SRST_LOAD = 6'h08,
    S_SRST_DSC = 6'h10,
    S_PACKET = 6'h20
  } ctl_state_e;

  typedef enum logic [1:0] {
    XK_PIO = 2'h0,
    XK_SWDMA = 2'h1,
    XK_MWDMA = 2'h2
  } xfer_kind_e;
endpackage

/* File: inc/ata_core_if.sv */
// carrier between the decoder core, the identification table and the mode decoder
`timescale 1ns/1ps
interface ata_core_if;
  logic [7:0] ident_index;
  logic [15:0] ident_word;
  logic [7:0] mode_code;
  logic mode_ok;
  ata_cmd_pkg::xfer_kind_e mode_kind;
  logic [2:0] mode_num;
  logic iordy_off;

  modport core(output ident_index, output mode_code, input ident_word, input mode_ok,
               input mode_kind, input mode_num, input iordy_off);
  modport rom(input ident_index, output ident_word);
  modport dec(input mode_code, output mode_ok, output mode_kind, output mode_num,
              output iordy_off);
endinterface

/* File: hw/ident_table.sv */
// identification block contents, one word per index
`timescale 1ns/1ps
`include "ata_cmd_defines.svh"
module ident_table (
  ata_core_if.rom port_if
);
  always_comb begin
    case (port_if.ident_index)
      `IDW_CONFIG: port_if.ident_word = `IDV_CONFIG;
      `IDW_BUF_TYPE: port_if.ident_word = `IDV_BUF_TYPE;
      `IDW_BUF_SIZE: port_if.ident_word = `IDV_BUF_SIZE;
      `IDW_CAPS: port_if.ident_word = `IDV_CAPS;
      `IDW_PIO_TIM, `IDW_DMA_TIM: port_if.ident_word = `IDV_TIM;
      `IDW_VALID: port_if.ident_word = `IDV_VALID;
      `IDW_SW_DMA, `IDW_MW_DMA: port_if.ident_word = `IDV_DMA_MODES;
      `IDW_PIO_ADV: port_if.ident_word = `IDV_PIO_ADV;
      default: begin
        // text fields are left blank here; unsupported words read zero
        if (port_if.ident_index >= `IDW_CYC_FIRST && port_if.ident_index <= `IDW_CYC_LAST) begin
          port_if.ident_word = `IDV_CYC;
        end else begin
          port_if.ident_word = `IDV_ZERO;
        end
      end
    endcase
  end
endmodule

/* File: hw/xfer_mode_decode.sv */
// decodes a transfer mode code into its kind and mode number
`timescale 1ns/1ps
`include "ata_cmd_defines.svh"
module xfer_mode_decode (
  ata_core_if.dec port_if
);
  logic [7:0] code;
  assign code = port_if.mode_code;

  always_comb begin
    port_if.mode_ok = 1'b1;
    port_if.mode_kind = ata_cmd_pkg::XK_PIO;
    port_if.mode_num = `PIO_NUM_DEF;
    port_if.iordy_off = 1'b0;
    if (code == `MODE_PIO_DEF) begin
      port_if.mode_num = `PIO_NUM_DEF;
    end else if (code == `MODE_PIO2_NORDY) begin
      port_if.mode_num = `PIO_NUM_NORDY;
      port_if.iordy_off = 1'b1;
    end else if (code >= `MODE_PIO_BASE && code <= `MODE_PIO_LAST) begin
      port_if.mode_num = 3'(code - `MODE_PIO_BASE);
    end else if (code >= `MODE_SW_BASE && code <= `MODE_SW_LAST) begin
      port_if.mode_kind = ata_cmd_pkg::XK_SWDMA;
      port_if.mode_num = 3'(code - `MODE_SW_BASE);
    end else if (code >= `MODE_MW_BASE && code <= `MODE_MW_LAST) begin
      port_if.mode_kind = ata_cmd_pkg::XK_MWDMA;
      port_if.mode_num = 3'(code - `MODE_MW_BASE);
    end else begin
      port_if.mode_ok = 1'b0;
    end
  end
endmodule

/* File: hw/ata_command_decoder.sv */
// ata-level command decoder and executor of a packet tape device
//
// Overview of operation
// - diagnostics run on any drive select, full reset
// - only master interrupts after diagnostics
// - idle immediate records idle, interrupts
// - standby immediate records standby, interrupts
// - check power returns state in reason, interrupts
// - standby reads 00h, everything else FFh
// - sleep acts as idle, stays responsive
// - set features aborts unsupported feature numbers
// - features 03h, 66h, CCh accepted; last two no-op
// - transfer mode from sector count, else abort
// - pio codes 00h, 01h, 08h to 0Ch
// - dma codes 10h-12h single, 20h-22h multi
// - mode sets rate; features bit picks dma
// - packet identify returns 256 words, data-in protocol
// - plain ata identify is aborted
// - word 0 is 81C0h
// - words 20, 21 are 4002h, 02D8h
// - word 49 0F00h, 51/52 0200h, 53 0002h
// - words 62, 63 are 0407h
// - word 64 0003h, words 65-68 0078h
// - read/write transfers use byte count 512
// - soft reset: full reset, then load and unit attention only with a cartridge present
// - seek complete set before busy clears
// - status bit layout, spare bits zero
// - abort sets error bit 2
// - features bit 0 selects dma or pio
`timescale 1ns/1ps
`include "ata_cmd_defines.svh"
module ata_command_decoder (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_cmd_valid,
  input wire logic [7:0] i_command,
  input wire logic [7:0] i_features,
  input wire logic [7:0] i_sector_count,
  input wire logic [15:0] i_byte_count,
  input wire logic i_dev_selected,
  input wire logic i_is_master,
  input wire logic i_cartridge_present,
  input wire logic i_rw_transfer,
  input wire logic i_diag_done,
  input wire logic i_load_done,
  input wire logic i_packet_done,
  input wire logic i_ident_rd,
  input wire logic i_status_read,
  input wire logic i_ua_clear,
  output logic [7:0] o_status,
  output logic [7:0] o_error,
  output logic [7:0] o_int_reason,
  output logic o_intrq,
  output logic o_cpu_reset,
  output logic o_run_diag,
  output logic o_start_load,
  output logic o_packet_start,
  output logic o_unit_attention,
  output logic o_partition_zero_start,
  output logic [2:0] o_pio_mode,
  output logic [2:0] o_sw_dma_mode,
  output logic [2:0] o_mw_dma_mode,
  output logic o_iordy_disable,
  output logic o_use_dma,
  output logic [2:0] o_rate_mode,
  output logic [15:0] o_xfer_byte_count,
  output logic [15:0] o_ident_data
);
  // ------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------
  logic [1:0] rst_pipe;
  logic rst_n;
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_pipe <= 2'b00;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[1];

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  ata_core_if core_if ();
  ident_table u_ident (.port_if(core_if.rom));
  xfer_mode_decode u_mode (.port_if(core_if.dec));

  ata_cmd_pkg::ctl_state_e state;
  logic bsy, drdy, dsc, drq, chk, standby, loading, dma_single;
  logic [7:0] ident_index, next_ident_index;
  logic take, is_diag, is_srst, is_ident, is_packet, is_imm, feat_ok, abort_now;
  logic ident_end, done_evt;

  // diagnostics bypass the drive select check
  assign take = i_cmd_valid && state == ata_cmd_pkg::S_IDLE
                && (i_dev_selected || i_command == `OP_DIAG);
  assign is_diag = i_command == `OP_DIAG;
  assign is_srst = i_command == `OP_SOFT_RST;
  assign is_ident = i_command == `OP_ATAPI_IDENT;
  assign is_packet = i_command == `OP_PACKET;
  assign core_if.mode_code = i_sector_count;
  always_comb begin
    case (i_features)
      `FEAT_XFER: feat_ok = core_if.mode_ok;
      `FEAT_NOREVERT, `FEAT_REVERT: feat_ok = 1'b1;
      default: feat_ok = 1'b0;
    endcase
  end
  assign is_imm = i_command == `OP_IDLE_IMM || i_command == `OP_STBY_IMM
                  || i_command == `OP_CHK_PWR || i_command == `OP_SLEEP
                  || (i_command == `OP_SET_FEAT && feat_ok);
  // anything not decoded, the plain identify included, is aborted
  assign abort_now = take && !(is_imm || is_diag || is_srst || is_ident || is_packet);
  assign ident_end = state == ata_cmd_pkg::S_IDENT && i_ident_rd
                     && ident_index == `IDENT_LAST;
  assign done_evt = (take && is_imm) || abort_now || ident_end
                    || (state == ata_cmd_pkg::S_DIAG && i_diag_done && i_is_master)
                    || (state == ata_cmd_pkg::S_PACKET && i_packet_done);

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ata_cmd_pkg::S_IDLE;
    end else begin
      case (state)
        ata_cmd_pkg::S_IDLE: begin
          if (take && is_diag) begin
            state <= ata_cmd_pkg::S_DIAG;
          end else if (take && is_ident) begin
            state <= ata_cmd_pkg::S_IDENT;
          end else if (take && is_srst) begin
            state <= ata_cmd_pkg::S_SRST_LOAD;
          end else if (take && is_packet) begin
            state <= ata_cmd_pkg::S_PACKET;
          end
        end
        ata_cmd_pkg::S_DIAG: if (i_diag_done) state <= ata_cmd_pkg::S_IDLE;
        ata_cmd_pkg::S_IDENT: if (ident_end) state <= ata_cmd_pkg::S_IDLE;
        ata_cmd_pkg::S_SRST_LOAD: begin
          if (!loading || i_load_done) state <= ata_cmd_pkg::S_SRST_DSC;
        end
        ata_cmd_pkg::S_SRST_DSC: state <= ata_cmd_pkg::S_IDLE;
        ata_cmd_pkg::S_PACKET: if (i_packet_done) state <= ata_cmd_pkg::S_IDLE;
        default: state <= ata_cmd_pkg::S_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // status and error
  // ------------------------------------------------------------
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      bsy <= 1'b0;
      drdy <= 1'b0;
      dsc <= 1'b0;
      drq <= 1'b0;
      chk <= 1'b0;
      o_error <= `ERR_RESET;
    end else if (abort_now) begin
      // ready and seek complete drop so the host sees the failure
      chk <= 1'b1;
      bsy <= 1'b0;
      drdy <= 1'b0;
      dsc <= 1'b0;
      o_error <= `ERR_ABORT;
    end else if (take) begin
      chk <= 1'b0;
      o_error <= `ERR_CLEAR;
      drdy <= !(is_diag || is_srst);
      bsy <= is_diag || is_srst || is_packet;
      drq <= is_ident;
      if (is_diag || is_srst) dsc <= 1'b0;
    end else begin
      case (state)
        ata_cmd_pkg::S_DIAG: begin
          if (i_diag_done) begin
            bsy <= 1'b0;
            o_error <= `ERR_RESET;
          end
        end
        ata_cmd_pkg::S_IDENT: if (ident_end) drq <= 1'b0;
        ata_cmd_pkg::S_SRST_LOAD: if (!loading || i_load_done) dsc <= 1'b1;
        ata_cmd_pkg::S_SRST_DSC: begin
          bsy <= 1'b0;
          o_error <= `ERR_RESET;
        end
        ata_cmd_pkg::S_PACKET: if (i_packet_done) bsy <= 1'b0;
        default: bsy <= bsy;
      endcase
    end
  end
  assign o_status = {bsy, drdy, 1'b0, dsc, drq, 1'b0, 1'b0, chk};

  // interrupt stays up until the host reads status or issues a command
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_intrq <= 1'b0;
    end else if (done_evt) begin
      o_intrq <= 1'b1;
    end else if (i_status_read || take) begin
      o_intrq <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // power state, emulated only
  // ------------------------------------------------------------
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      standby <= 1'b0;
      o_int_reason <= `IRSN_RESET;
    end else if (take && !abort_now) begin
      if (i_command == `OP_CHK_PWR) begin
        o_int_reason <= standby ? `PWR_STANDBY : `PWR_IDLE;
      end else begin
        // sleep falls here and simply reads back as idle
        standby <= i_command == `OP_STBY_IMM;
      end
    end
  end

  // ------------------------------------------------------------
  // one-cycle requests to the rest of the drive
  // ------------------------------------------------------------
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_cpu_reset <= 1'b0;
      o_run_diag <= 1'b0;
      o_start_load <= 1'b0;
      o_packet_start <= 1'b0;
      loading <= 1'b0;
    end else begin
      o_cpu_reset <= take && (is_diag || is_srst);
      o_run_diag <= take && is_diag;
      o_start_load <= take && is_srst && i_cartridge_present;
      o_packet_start <= take && is_packet;
      if (take && is_srst) loading <= i_cartridge_present;
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_unit_attention <= 1'b0;
      o_partition_zero_start <= 1'b0;
    end else if (state == ata_cmd_pkg::S_SRST_LOAD && loading && i_load_done) begin
      o_unit_attention <= 1'b1;
      o_partition_zero_start <= 1'b1;
    end else begin
      if (i_ua_clear) o_unit_attention <= 1'b0;
      if (take && (is_diag || is_srst || is_packet)) o_partition_zero_start <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // transfer modes and data phase selection
  // ------------------------------------------------------------
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_pio_mode <= `PIO_NUM_DEF;
      o_sw_dma_mode <= `DMA_NUM_DEF;
      o_mw_dma_mode <= `DMA_NUM_DEF;
      o_iordy_disable <= 1'b0;
      dma_single <= 1'b0;
    end else if (take && i_command == `OP_SET_FEAT && i_features == `FEAT_XFER
                 && core_if.mode_ok) begin
      case (core_if.mode_kind)
        ata_cmd_pkg::XK_SWDMA: begin
          o_sw_dma_mode <= core_if.mode_num;
          dma_single <= 1'b1;
        end
        ata_cmd_pkg::XK_MWDMA: begin
          o_mw_dma_mode <= core_if.mode_num;
          dma_single <= 1'b0;
        end
        default: begin
          o_pio_mode <= core_if.mode_num;
          o_iordy_disable <= core_if.iordy_off;
        end
      endcase
    end
  end

  // the mode only sets a rate; the features bit alone picks the data path
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_use_dma <= 1'b0;
      o_xfer_byte_count <= `MIN_RW_BYTES;
    end else if (take && is_packet) begin
      o_use_dma <= i_features[`FEAT_DMA_BIT];
      // host figure is ignored for read and write streams
      o_xfer_byte_count <= i_rw_transfer ? `MIN_RW_BYTES : i_byte_count;
    end
  end
  assign o_rate_mode = !o_use_dma ? o_pio_mode
                       : (dma_single ? o_sw_dma_mode : o_mw_dma_mode);

  // ------------------------------------------------------------
  // identification data phase
  // ------------------------------------------------------------
  always_comb begin
    next_ident_index = ident_index;
    if (take && is_ident) begin
      next_ident_index = 8'h00;
    end else if (state == ata_cmd_pkg::S_IDENT && i_ident_rd) begin
      next_ident_index = 8'(ident_index + 8'h01);
    end
  end
  assign core_if.ident_index = next_ident_index;

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      ident_index <= 8'h00;
      o_ident_data <= 16'h0000;
    end else begin
      ident_index <= next_ident_index;
      o_ident_data <= core_if.ident_word;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!rst_n);

  sequence srst_dsc_first;
    o_status[`ST_BSY] && o_status[`ST_DSC];
  endsequence
  sequence srst_bsy_clear;
    !o_status[`ST_BSY] && o_status[`ST_DSC] && o_error == `ERR_RESET;
  endsequence

  a_diag_any_drive: assert property (i_cmd_valid && state == ata_cmd_pkg::S_IDLE
    && i_command == `OP_DIAG |=> o_cpu_reset && o_run_diag && o_status[`ST_BSY])
    else $error("diagnostics not started");
  a_diag_slave_quiet: assert property (state == ata_cmd_pkg::S_DIAG && i_diag_done
    && !i_is_master && !o_intrq |=> !o_intrq)
    else $error("slave raised interrupt after diagnostics");
  a_idle_record: assert property (take && i_command == `OP_IDLE_IMM
    |=> !standby && o_intrq ##1 (o_intrq || $past(i_status_read) || $past(take)))
    else $error("idle immediate not recorded");
  a_standby_report: assert property (take && i_command == `OP_STBY_IMM ##1
    (take && i_command == `OP_CHK_PWR) |=> o_int_reason == `PWR_STANDBY && o_intrq)
    else $error("standby not reported as 00h");
  a_power_reason: assert property (take && i_command == `OP_CHK_PWR
    |=> o_int_reason == ($past(standby) ? `PWR_STANDBY : `PWR_IDLE))
    else $error("power state reason wrong");
  a_feature_abort: assert property (take && i_command == `OP_SET_FEAT && !feat_ok
    |=> o_error[`ERR_ABRT_BIT] && o_status[`ST_CHK] && !o_status[`ST_BSY] && o_intrq)
    else $error("unsupported feature not aborted");
  a_ata_ident_abort: assert property (take && i_command == `OP_ATA_IDENT
    |=> o_error == `ERR_ABORT && !o_status[`ST_DRQ])
    else $error("plain identify not aborted");
  a_ident_start: assert property (take && is_ident
    |=> o_status[`ST_DRQ] && o_ident_data == `IDV_CONFIG)
    else $error("identify data phase not started");
  a_srst_order: assert property (state == ata_cmd_pkg::S_SRST_DSC
    |-> srst_dsc_first ##1 srst_bsy_clear)
    else $error("busy cleared before seek complete");
  a_dma_select: assert property (take && is_packet
    |=> o_use_dma == $past(i_features[`FEAT_DMA_BIT]))
    else $error("data path not taken from features bit");
endmodule

/* File: dv/far_side_model.sv */
// far-side engines: diagnostics, cartridge load and packet layer
`timescale 1ns/1ps
module far_side_model (
  input wire logic i_clk,
  input wire logic i_run_diag,
  input wire logic i_start_load,
  input wire logic i_packet_start,
  output logic o_diag_done,
  output logic o_load_done,
  output logic o_packet_done
);
  // ------------------------------------------------------------
  // delayed one-cycle completions
  // ------------------------------------------------------------
  logic [2:0] start;
  logic [2:0] done = 3'h0;
  int cnt [3] = '{0, 0, 0};
  assign start = {i_packet_start, i_start_load, i_run_diag};
  assign {o_packet_done, o_load_done, o_diag_done} = done;
  // unequal delays so no two engines finish on the same edge
  always @(negedge i_clk) begin
    for (int j = 0; j < 3; j++) begin
      done[j] = (cnt[j] == 1);
      if (start[j]) begin
        cnt[j] = 5 + j;
      end else if (cnt[j] > 0) begin
        cnt[j]--;
      end
    end
  end
endmodule

/* File: dv/tb_ata_command_decoder.sv */
// self-checking bench for the command decoder
`timescale 1ns/1ps
module tb_ata_command_decoder;
  logic clk = 1'b0, rst_n = 1'b0, vld = 1'b0, sel = 1'b1, mst = 1'b1, cart = 1'b1;
  logic rw = 1'b0, ird = 1'b0, srd = 1'b0, uac = 1'b0;
  logic [7:0] cmd = 8'h00, feat = 8'h00, sc = 8'h00, prev;
  logic [15:0] bc = 16'h0000, xbc, idw;
  logic dd, ld, pd, run_diag, st_load, pk_start, ua, p0, iod, udma, irq;
  logic [7:0] st, er, ir;
  logic [2:0] pio, sw, mw, rate;
  logic [7:0] codes [13] = '{8'h00, 8'h01, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h10, 8'h11,
                             8'h12, 8'h20, 8'h21, 8'h22};
  int fail_count = 0, n_checks = 0;
  always #2 clk = ~clk;
  ata_command_decoder DUT (.i_clk(clk), .i_reset_n(rst_n), .i_cmd_valid(vld), .i_command(cmd),
    .i_features(feat), .i_sector_count(sc), .i_byte_count(bc), .i_dev_selected(sel),
    .i_is_master(mst), .i_cartridge_present(cart), .i_rw_transfer(rw), .i_diag_done(dd),
    .i_load_done(ld), .i_packet_done(pd), .i_ident_rd(ird), .i_status_read(srd),
    .i_ua_clear(uac), .o_status(st), .o_error(er), .o_int_reason(ir), .o_intrq(irq),
    .o_cpu_reset(), .o_run_diag(run_diag), .o_start_load(st_load), .o_packet_start(pk_start),
    .o_unit_attention(ua), .o_partition_zero_start(p0), .o_pio_mode(pio),
    .o_sw_dma_mode(sw), .o_mw_dma_mode(mw), .o_iordy_disable(iod), .o_use_dma(udma),
    .o_rate_mode(rate), .o_xfer_byte_count(xbc), .o_ident_data(idw));
  far_side_model partner (.i_clk(clk), .i_run_diag(run_diag), .i_start_load(st_load),
    .i_packet_start(pk_start), .o_diag_done(dd), .o_load_done(ld), .o_packet_done(pd));
  // ------------------------------------------------------------
  // access tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // status read first so every command starts with the interrupt low
  task automatic issue(input logic [7:0] op, input logic [7:0] f, input logic [7:0] s);
    @(negedge clk) srd = 1'b1;
    @(negedge clk) srd = 1'b0;
    vld = 1'b1;
    cmd = op;
    feat = f;
    sc = s;
    @(negedge clk) vld = 1'b0;
    @(negedge clk);
  endtask
  task automatic wait_idle;
    prev = st;
    for (int k = 0; k < 400 && (st[7] || st[3]); k++) begin
      prev = st;
      @(negedge clk);
    end
  endtask
  function automatic logic [15:0] idexp(input int k);
    case (k)
      0: return 16'h81C0;
      20: return 16'h4002;
      21: return 16'h02D8;
      49: return 16'h0F00;
      51, 52: return 16'h0200;
      53: return 16'h0002;
      62, 63: return 16'h0407;
      64: return 16'h0003;
      65, 66, 67, 68: return 16'h0078;
      default: return 16'h0000;
    endcase
  endfunction
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    chk("status", st, 16'h0000);
    chk("reason", ir, 16'h0001);
    chk("xfer_count", xbc, 16'h0200);
    issue(8'hE5, 8'h00, 8'h00);
    chk("reason", ir, 16'h00FF);
    issue(8'hE0, 8'h00, 8'h00);
    chk("irq", irq, 16'h1);
    issue(8'hE5, 8'h00, 8'h00);
    chk("reason", ir, 16'h0000);
    chk("busy_ready", st[7:6], 16'h1);
    issue(8'hE1, 8'h00, 8'h00);
    chk("irq", irq, 16'h1);
    issue(8'hE5, 8'h00, 8'h00);
    chk("reason", ir, 16'h00FF);
    issue(8'hE0, 8'h00, 8'h00);
    issue(8'hE6, 8'h00, 8'h00);
    issue(8'hE5, 8'h00, 8'h00);
    chk("reason", ir, 16'h00FF);
    // immediate commands back to back, no status read between them
    @(negedge clk) vld = 1'b1;
    cmd = 8'hE0;
    @(negedge clk) cmd = 8'hE5;
    @(negedge clk) vld = 1'b0;
    @(negedge clk);
    chk("reason", ir, 16'h0000);
    issue(8'hEF, 8'h66, 8'h00);
    chk("error", er, 16'h0000);
    issue(8'hEF, 8'hCC, 8'h00);
    chk("error", er, 16'h0000);
    issue(8'hEF, 8'h55, 8'h00);
    chk("error", er, 16'h0004);
    chk("status", st, 16'h0001);
    chk("irq", irq, 16'h1);
    foreach (codes[i]) begin
      issue(8'hEF, 8'h03, codes[i]);
      chk("error", er, 16'h0000);
      if (codes[i] < 8'h10) begin
        chk("pio", pio, 16'(codes[i] == 8'h00 ? 8'h04 : codes[i] == 8'h01 ? 8'h02
                            : codes[i] - 8'h08));
        chk("iordy_off", iod, 16'(codes[i] == 8'h01));
      end else if (codes[i] < 8'h20) chk("sw_dma", sw, 16'(codes[i] - 8'h10));
      else chk("mw_dma", mw, 16'(codes[i] - 8'h20));
    end
    foreach (codes[i]) begin
      issue(8'hEF, 8'h03, codes[i] + 8'h03);
      if (!(codes[i] inside {8'h08, 8'h09})) chk("error", er, 16'h0004);
    end
    issue(8'hEF, 8'h03, 8'h21);
    issue(8'hEF, 8'h03, 8'h0A);
    rw = 1'b1;
    bc = 16'h0100;
    issue(8'hA0, 8'h01, 8'h00);
    chk("xfer_count", xbc, 16'h0200);
    chk("use_dma", udma, 16'h1);
    chk("rate", rate, 16'h1);
    wait_idle();
    chk("irq", irq, 16'h1);
    rw = 1'b0;
    bc = 16'h0400;
    issue(8'hA0, 8'h00, 8'h00);
    chk("xfer_count", xbc, 16'h0400);
    chk("use_dma", udma, 16'h0);
    chk("rate", rate, 16'h2);
    wait_idle();
    issue(8'hEC, 8'h00, 8'h00);
    chk("error", er, 16'h0004);
    issue(8'hA1, 8'h00, 8'h00);
    chk("drq", st[3], 16'h1);
    for (int k = 0; k < 256; k++) begin
      chk("ident", idw, idexp(k));
      ird = 1'b1;
      @(negedge clk);
    end
    ird = 1'b0;
    @(negedge clk);
    chk("drq", st[3], 16'h0);
    chk("irq", irq, 16'h1);
    sel = 1'b0;
    issue(8'h90, 8'h00, 8'h00);
    wait_idle();
    chk("error", er, 16'h0001);
    chk("irq", irq, 16'h1);
    mst = 1'b0;
    issue(8'h90, 8'h00, 8'h00);
    wait_idle();
    chk("irq", irq, 16'h0);
    sel = 1'b1;
    issue(8'h08, 8'h00, 8'h00);
    wait_idle();
    chk("seek_before_ready", prev[4], 16'h1);
    chk("status", st, 16'h0010);
    chk("unit_attention", ua, 16'h1);
    chk("partition_zero", p0, 16'h1);
    @(negedge clk) uac = 1'b1;
    @(negedge clk) uac = 1'b0;
    chk("unit_attention", ua, 16'h0);
    cart = 1'b0;
    issue(8'h08, 8'h00, 8'h00);
    wait_idle();
    chk("status", st, 16'h0010);
    chk("unit_attention", ua, 16'h0);
    chk("partition_zero", p0, 16'h0);
    complete_run();
  end
  // the sequence needs about 500 cycles
  initial begin
    #40000;
    fail_count++;
    complete_run();
  end
endmodule
